// >>> logic/adcsd_pkg.sv
package adcsd_pkg;

  // --------------------------------------------------------------
  // Command byte fields
  // --------------------------------------------------------------
  localparam int unsigned CMD_CONV_BIT  = 7;
  localparam int unsigned CMD_SETUP_BIT = 6;
  localparam int unsigned CONV_CH_HI    = 5;
  localparam int unsigned CONV_CH_LO    = 3;
  localparam int unsigned CONV_SCAN_HI  = 2;
  localparam int unsigned CONV_SCAN_LO  = 1;
  localparam int unsigned CONV_TEMP_BIT = 0;
  localparam int unsigned SET_CLK_HI    = 5;
  localparam int unsigned SET_CLK_LO    = 4;
  localparam int unsigned SET_REF_HI    = 3;
  localparam int unsigned SET_REF_LO    = 2;
  localparam int unsigned SET_DIFF_HI   = 1;
  localparam int unsigned SET_DIFF_LO   = 0;

  // --------------------------------------------------------------
  // Reset values and mode codes
  // --------------------------------------------------------------
  localparam logic [7:0] SETUP_RST    = 8'h28;
  localparam logic [7:0] CONV_RST     = 8'h00;
  localparam logic [1:0] SCAN_LOW     = 2'h0;
  localparam logic [1:0] SCAN_HIGH    = 2'h1;
  localparam logic [1:0] SCAN_REPEAT  = 2'h2;
  localparam logic [1:0] SCAN_SINGLE  = 2'h3;
  localparam logic [1:0] CLK_SAMPLE_X = 2'h1;
  localparam logic [1:0] CLK_SCLK     = 2'h3;
  localparam logic [1:0] REF_INT      = 2'h0;
  localparam logic [1:0] REF_EXT      = 2'h1;
  localparam logic [1:0] REF_INT_ADC  = 2'h2;
  localparam logic [1:0] REF_EXT_DIFF = 2'h3;
  localparam logic [1:0] ADC_REF_INT  = 2'h0;
  localparam logic [1:0] ADC_REF_EXT2 = 2'h1;
  localparam logic [1:0] ADC_REF_DIFF = 2'h2;

  // --------------------------------------------------------------
  // Channels, counts and temperature
  // --------------------------------------------------------------
  localparam logic [3:0]  CH_TOP          = 4'h7;
  localparam logic [2:0]  CH_START_PIN    = 3'h7;
  localparam logic [2:0]  CH_SECOND_REF   = 3'h6;
  localparam logic [7:0]  DLY_REF_HELD    = 8'hBC;
  localparam logic [7:0]  DLY_REF_WAKE    = 8'hF4;
  localparam logic [4:0]  REPEAT_UNIT     = 5'h04;
  localparam logic [11:0] TEMP_KELVIN_OFS = 12'h889;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SETTLE  = 5'b00010,
    ST_TEMP_HI = 5'b00100,
    ST_TEMP_LO = 5'b01000,
    ST_CHAN    = 5'b10000
  } adcsd_state_e;

endpackage

// >>> logic/adcsd_top.sv
`timescale 1ns/1ps
module adcsd_top
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        link_sclk_i,
  input  wire logic        link_cs_n_i,
  input  wire logic        link_mosi_i,
  input  wire logic        convert_start_pin_n_i,
  input  wire logic        force_ref_on_i,
  input  wire logic        dac_ref_load_i,
  input  wire logic [3:0]  diff_pair_i,
  input  wire logic [1:0]  repeat_count_sel_i,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  input  wire logic        temp_read_i,
  output logic             conv_req_o,
  output logic [2:0]       conv_chan_o,
  output logic             conv_diff_o,
  output logic             conv_temp_o,
  output logic             conv_bias_hi_o,
  output logic             conv_int_ref_o,
  output logic             conv_sclk_timed_o,
  output logic             sample_ext_timed_o,
  output logic             pin7_is_input_o,
  output logic             ref2_is_input_o,
  output logic [1:0]       adc_ref_o,
  output logic             dac_ref_ext_o,
  output logic             ref_on_o,
  output logic [1:0]       diff_config_sel_o,
  output logic             diff_config_wr_o,
  output logic             res_valid_o,
  output logic [11:0]      res_data_o,
  output logic             res_is_temp_o,
  output logic [2:0]       res_chan_o,
  output logic             temp_pending_o,
  output logic [11:0]      temp_result_o,
  output logic             scan_busy_o
);

  // --------------------------------------------------------------
  // Link side: command byte capture on the serial clock
  // --------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] cmd_byte_q;
  logic       byte_rdy_q;
  logic       frame_ok_q;

  // Counts bits of the frame; chip select high clears it
  always_ff @(negedge link_sclk_i or posedge link_cs_n_i)
  begin
    if (link_cs_n_i)
    begin
      bit_cnt_q  <= 3'h0;
      byte_rdy_q <= 1'b0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7)
        byte_rdy_q <= 1'b1;
    end
  end

  // Shifts data in MSB first; only the frame's first byte is kept
  // Full-byte flag survives the frame end so the slow side can see it
  always_ff @(negedge link_sclk_i)
  begin
    shift_q <= {shift_q[5:0], link_mosi_i};
    if (!byte_rdy_q)
      frame_ok_q <= (bit_cnt_q == 3'h7);
    if (bit_cnt_q == 3'h7 && !byte_rdy_q)
      cmd_byte_q <= {shift_q, link_mosi_i};
  end

  // --------------------------------------------------------------
  // Crossing: end of frame into the system domain
  // --------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cnv_s1_q;
  logic cnv_s2_q;
  logic cnv_s3_q;
  logic cmd_stb;
  logic cnv_fall;

  // Two flops per level; the third one only serves edge detection
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      cnv_s1_q <= 1'b1;
      cnv_s2_q <= 1'b1;
      cnv_s3_q <= 1'b1;
    end
    else
    begin
      cs_s1_q  <= link_cs_n_i;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      cnv_s1_q <= convert_start_pin_n_i;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
    end
  end

  // Byte and flag stay still until the next frame, long after they are read
  assign cmd_stb  = cs_s2_q & ~cs_s3_q & frame_ok_q;
  assign cnv_fall = cnv_s3_q & ~cnv_s2_q;

  // --------------------------------------------------------------
  // Command decode and registers
  // --------------------------------------------------------------
  logic [7:0] conv_q;
  logic [7:0] setup_q;
  logic       go_q;
  logic       conv_wr;
  logic       setup_wr;

  assign conv_wr  = cmd_stb & cmd_byte_q[adcsd_pkg::CMD_CONV_BIT];
  assign setup_wr = cmd_stb & ~cmd_byte_q[adcsd_pkg::CMD_CONV_BIT]
                  & cmd_byte_q[adcsd_pkg::CMD_SETUP_BIT];

  // Stores the two command registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      conv_q  <= adcsd_pkg::CONV_RST;
      setup_q <= adcsd_pkg::SETUP_RST;
    end
    else
    begin
      if (conv_wr)
        conv_q <= cmd_byte_q;
      if (setup_wr)
        setup_q <= cmd_byte_q;
    end
  end

  // Raises a scan start from a write or the start pin
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      go_q <= 1'b0;
    else
      go_q <= (conv_wr & setup_q[adcsd_pkg::SET_CLK_HI])
            | (cnv_fall & ~setup_q[adcsd_pkg::SET_CLK_HI]);
  end

  // Differential register address and its write strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      diff_config_sel_o <= 2'h0;
      diff_config_wr_o  <= 1'b0;
    end
    else
    begin
      diff_config_wr_o <= setup_wr
                        & (cmd_byte_q[adcsd_pkg::SET_DIFF_HI:adcsd_pkg::SET_DIFF_LO]
                           != 2'h0);
      if (setup_wr)
        diff_config_sel_o <= cmd_byte_q[adcsd_pkg::SET_DIFF_HI:adcsd_pkg::SET_DIFF_LO];
    end
  end

  // --------------------------------------------------------------
  // Reference routing and clock mode steering
  // --------------------------------------------------------------
  logic [1:0] ref_sel;
  logic [1:0] clk_mode;
  logic       ref_held;
  adcsd_pkg::adcsd_state_e state_q;

  assign ref_sel  = setup_q[adcsd_pkg::SET_REF_HI:adcsd_pkg::SET_REF_LO];
  assign clk_mode = setup_q[adcsd_pkg::SET_CLK_HI:adcsd_pkg::SET_CLK_LO];
  assign ref_held = force_ref_on_i
                  | ((ref_sel == adcsd_pkg::REF_INT) & dac_ref_load_i);

  // Registers routing outputs from the configuration
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      adc_ref_o          <= adcsd_pkg::ADC_REF_INT;
      dac_ref_ext_o      <= 1'b1;
      ref2_is_input_o    <= 1'b1;
      ref_on_o           <= 1'b0;
      conv_sclk_timed_o  <= 1'b0;
      sample_ext_timed_o <= 1'b0;
      pin7_is_input_o    <= 1'b1;
    end
    else
    begin
      unique case (ref_sel)
        adcsd_pkg::REF_INT:
        begin
          adc_ref_o     <= adcsd_pkg::ADC_REF_INT;
          dac_ref_ext_o <= 1'b0;
        end
        adcsd_pkg::REF_INT_ADC:
        begin
          adc_ref_o     <= adcsd_pkg::ADC_REF_INT;
          dac_ref_ext_o <= 1'b1;
        end
        adcsd_pkg::REF_EXT:
        begin
          adc_ref_o     <= adcsd_pkg::ADC_REF_EXT2;
          dac_ref_ext_o <= 1'b1;
        end
        adcsd_pkg::REF_EXT_DIFF:
        begin
          adc_ref_o     <= adcsd_pkg::ADC_REF_DIFF;
          dac_ref_ext_o <= 1'b1;
        end
      endcase
      ref2_is_input_o    <= ~ref_sel[0];
      ref_on_o           <= ref_held | (state_q != adcsd_pkg::ST_IDLE);
      conv_sclk_timed_o  <= (clk_mode == adcsd_pkg::CLK_SCLK);
      sample_ext_timed_o <= (clk_mode == adcsd_pkg::CLK_SAMPLE_X);
      pin7_is_input_o    <= clk_mode[1];
    end
  end

  // --------------------------------------------------------------
  // Channel selection for the scan in progress
  // --------------------------------------------------------------
  logic [2:0]  cur_q;
  logic [3:0]  last_q;
  logic [4:0]  rep_q;
  logic [7:0]  dly_q;
  logic        busy_q;
  logic [11:0] temp_hi_q;
  logic        pair_on;
  logic [2:0]  eff_ch;
  logic [3:0]  nxt_ch;
  logic        skip;
  logic        scan_end;
  logic [11:0] temp_val;

  // Differential pairs drop the lowest select bit and step by two
  assign pair_on = diff_pair_i[cur_q[2:1]];
  assign eff_ch  = pair_on ? {cur_q[2:1], 1'b0} : cur_q;
  assign nxt_ch  = {1'b0, eff_ch} + (pair_on ? 4'h2 : 4'h1);

  // Channels standing in as start pin or reference are skipped
  always_comb
  begin
    skip = 1'b0;
    if (~clk_mode[1] && (eff_ch == adcsd_pkg::CH_START_PIN
        || (pair_on && eff_ch == adcsd_pkg::CH_SECOND_REF)))
      skip = 1'b1;
    if (ref_sel[0] && eff_ch == adcsd_pkg::CH_SECOND_REF)
      skip = 1'b1;
  end

  // Repeat mode ends on its count or on a skipped channel, other modes past the last channel
  assign scan_end = (conv_q[adcsd_pkg::CONV_SCAN_HI:adcsd_pkg::CONV_SCAN_LO]
                     == adcsd_pkg::SCAN_REPEAT)
                  ? (rep_q == 5'h01) | skip
                  : (nxt_ch > last_q);

  // High-bias minus low-bias, shifted from Kelvin to Celsius
  assign temp_val = temp_hi_q - conv_data_i - adcsd_pkg::TEMP_KELVIN_OFS;

  // --------------------------------------------------------------
  // Scan sequencer
  // --------------------------------------------------------------
  // Walks temperature first, then the channel range
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q        <= adcsd_pkg::ST_IDLE;
      cur_q          <= 3'h0;
      last_q         <= 4'h0;
      rep_q          <= 5'h00;
      dly_q          <= 8'h00;
      busy_q         <= 1'b0;
      temp_hi_q      <= 12'h000;
      conv_req_o     <= 1'b0;
      conv_chan_o    <= 3'h0;
      conv_diff_o    <= 1'b0;
      conv_temp_o    <= 1'b0;
      conv_bias_hi_o <= 1'b0;
      conv_int_ref_o <= 1'b0;
      res_valid_o    <= 1'b0;
      res_data_o     <= 12'h000;
      res_is_temp_o  <= 1'b0;
      res_chan_o     <= 3'h0;
      scan_busy_o    <= 1'b0;
    end
    else
    begin
      conv_req_o  <= 1'b0;
      res_valid_o <= 1'b0;
      unique case (state_q)
        adcsd_pkg::ST_IDLE:
        begin
          scan_busy_o <= 1'b0;
          if (go_q)
          begin
            scan_busy_o <= 1'b1;
            rep_q <= {repeat_count_sel_i, 2'h0} + adcsd_pkg::REPEAT_UNIT;
            unique case (conv_q[adcsd_pkg::CONV_SCAN_HI:adcsd_pkg::CONV_SCAN_LO])
              adcsd_pkg::SCAN_LOW:
              begin
                cur_q  <= 3'h0;
                last_q <= {1'b0, conv_q[adcsd_pkg::CONV_CH_HI:adcsd_pkg::CONV_CH_LO]};
              end
              adcsd_pkg::SCAN_HIGH:
              begin
                cur_q  <= conv_q[adcsd_pkg::CONV_CH_HI:adcsd_pkg::CONV_CH_LO];
                last_q <= adcsd_pkg::CH_TOP;
              end
              default:
              begin
                cur_q  <= conv_q[adcsd_pkg::CONV_CH_HI:adcsd_pkg::CONV_CH_LO];
                last_q <= {1'b0, conv_q[adcsd_pkg::CONV_CH_HI:adcsd_pkg::CONV_CH_LO]};
              end
            endcase
            if (conv_q[adcsd_pkg::CONV_TEMP_BIT])
            begin
              state_q <= adcsd_pkg::ST_SETTLE;
              dly_q   <= ref_held ? adcsd_pkg::DLY_REF_HELD
                                  : adcsd_pkg::DLY_REF_WAKE;
            end
            else
              state_q <= adcsd_pkg::ST_CHAN;
          end
        end
        adcsd_pkg::ST_SETTLE:
        begin
          dly_q <= dly_q - 8'h01;
          if (dly_q == 8'h01)
            state_q <= adcsd_pkg::ST_TEMP_HI;
        end
        adcsd_pkg::ST_TEMP_HI, adcsd_pkg::ST_TEMP_LO:
        begin
          if (!busy_q)
          begin
            busy_q         <= 1'b1;
            conv_req_o     <= 1'b1;
            conv_temp_o    <= 1'b1;
            conv_int_ref_o <= 1'b1;
            conv_bias_hi_o <= (state_q == adcsd_pkg::ST_TEMP_HI);
          end
          else if (conv_done_i)
          begin
            busy_q <= 1'b0;
            if (state_q == adcsd_pkg::ST_TEMP_HI)
            begin
              temp_hi_q <= conv_data_i;
              state_q   <= adcsd_pkg::ST_TEMP_LO;
            end
            else
            begin
              res_valid_o   <= 1'b1;
              res_data_o    <= temp_val;
              res_is_temp_o <= 1'b1;
              state_q       <= adcsd_pkg::ST_CHAN;
            end
          end
        end
        adcsd_pkg::ST_CHAN:
        begin
          if (!busy_q && skip)
          begin
            cur_q <= nxt_ch[2:0];
            if (scan_end)
              state_q <= adcsd_pkg::ST_IDLE;
          end
          else if (!busy_q)
          begin
            busy_q         <= 1'b1;
            conv_req_o     <= 1'b1;
            conv_chan_o    <= eff_ch;
            conv_diff_o    <= pair_on;
            conv_temp_o    <= 1'b0;
            conv_bias_hi_o <= 1'b0;
            conv_int_ref_o <= (ref_sel[0] == 1'b0);
          end
          else if (conv_done_i)
          begin
            busy_q        <= 1'b0;
            res_valid_o   <= 1'b1;
            res_data_o    <= conv_data_i;
            res_is_temp_o <= 1'b0;
            res_chan_o    <= eff_ch;
            rep_q         <= rep_q - 5'h01;
            if (conv_q[adcsd_pkg::CONV_SCAN_HI:adcsd_pkg::CONV_SCAN_LO]
                != adcsd_pkg::SCAN_REPEAT)
              cur_q <= nxt_ch[2:0];
            if (scan_end)
              state_q <= adcsd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Held temperature result
  // --------------------------------------------------------------
  // A newer result overwrites; a fresh result beats a read clear
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      temp_pending_o <= 1'b0;
      temp_result_o  <= 12'h000;
    end
    else if (state_q == adcsd_pkg::ST_TEMP_LO && busy_q && conv_done_i)
    begin
      temp_pending_o <= 1'b1;
      temp_result_o  <= temp_val;
    end
    else if (temp_read_i)
      temp_pending_o <= 1'b0;
  end

endmodule // adcsd_top

// >>> verif/adcsd_assertions.sv
`timescale 1ns/1ps
module adcsd_assertions
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        force_ref_on_i,
  input  wire logic        conv_done_i,
  input  wire logic        conv_req_o,
  input  wire logic [2:0]  conv_chan_o,
  input  wire logic        conv_diff_o,
  input  wire logic        conv_temp_o,
  input  wire logic        conv_bias_hi_o,
  input  wire logic        conv_int_ref_o,
  input  wire logic        pin7_is_input_o,
  input  wire logic        ref2_is_input_o,
  input  wire logic [1:0]  adc_ref_o,
  input  wire logic        dac_ref_ext_o,
  input  wire logic        ref_on_o,
  input  wire logic        res_valid_o,
  input  wire logic [11:0] res_data_o,
  input  wire logic        res_is_temp_o,
  input  wire logic [11:0] temp_result_o,
  input  wire logic        scan_busy_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic [8:0] busy_cnt_q;

  // Cycles spent busy in the current scan, saturating
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !scan_busy_o)
      busy_cnt_q <= 9'h000;
    else if (busy_cnt_q != 9'h1FF)
      busy_cnt_q <= busy_cnt_q + 9'h001;
  end

  ref_map_a:
    assert property (ref2_is_input_o == (adc_ref_o == adcsd_pkg::ADC_REF_INT)
      && (dac_ref_ext_o || ref2_is_input_o)) else $error("reference routing wrong");
  pair_even_a:
    assert property (conv_req_o && conv_diff_o |-> !conv_chan_o[0])
    else $error("pair request on odd channel");
  temp_iref_a:
    assert property (conv_req_o && conv_temp_o |-> conv_int_ref_o)
    else $error("temperature without internal reference");
  skip_chan_a:
    assert property (conv_req_o && !conv_temp_o |->
      !(!pin7_is_input_o && conv_chan_o == adcsd_pkg::CH_START_PIN)
      && !(!ref2_is_input_o && conv_chan_o == adcsd_pkg::CH_SECOND_REF))
    else $error("conversion on reserved pin");
  res_done_a:
    assert property (res_valid_o && !res_is_temp_o |-> $past(conv_done_i))
    else $error("result without converter done");
  busy_req_a:
    assert property (conv_req_o |-> scan_busy_o) else $error("request outside scan");
  ref_hold_a:
    assert property (force_ref_on_i [*3] |-> ref_on_o) else $error("reference not held");
  temp_keep_a:
    assert property (res_valid_o && res_is_temp_o |=> temp_result_o == $past(res_data_o))
    else $error("temperature not stored");
  temp_wait_a:
    assert property (conv_req_o && conv_temp_o && conv_bias_hi_o |-> busy_cnt_q >= 9'h0BA)
    else $error("temperature started early");

  cover property (conv_req_o && conv_temp_o);
  cover property (conv_req_o && conv_diff_o);
  cover property (res_valid_o && !res_is_temp_o);
endmodule // adcsd_assertions

bind adcsd_top adcsd_assertions u_chk (.clk_sys_i, .rst_i, .force_ref_on_i, .conv_done_i,
  .conv_req_o, .conv_chan_o, .conv_diff_o, .conv_temp_o, .conv_bias_hi_o, .conv_int_ref_o,
  .pin7_is_input_o, .ref2_is_input_o, .adc_ref_o, .dac_ref_ext_o, .ref_on_o, .res_valid_o,
  .res_data_o, .res_is_temp_o, .temp_result_o, .scan_busy_o);

// >>> verif/adcsd_host_model.sv
`timescale 1ns/1ps
module adcsd_host_model
(
  output logic link_sclk_o,
  output logic link_cs_n_o,
  output logic link_mosi_o
);
  // Clock idles low; select rises once so the link starts clean
  initial
  begin
    link_sclk_o = 1'b0;
    link_cs_n_o = 1'b0;
    link_mosi_o = 1'b0;
    #5 link_cs_n_o = 1'b1;
  end

  // One command byte per frame, MSB first, clock only inside the frame
  task automatic send(input logic [7:0] b);
    int i;
    #7 link_cs_n_o = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      #1 link_mosi_o = b[i];
      #14 link_sclk_o = 1'b1;
      #15 link_sclk_o = 1'b0;
    end
    #15 link_cs_n_o = 1'b1;
    link_mosi_o = ~link_mosi_o;
    #100;
  endtask
endmodule // adcsd_host_model

// >>> verif/adc_scan_setup_decode_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_scan_setup_decode_tb;
  logic        clk_sys_i, rst_i, link_sclk_i, link_cs_n_i, link_mosi_i, busy_d;
  logic        convert_start_pin_n_i, force_ref_on_i, dac_ref_load_i, conv_done_i;
  logic        temp_read_i, conv_req_o, conv_diff_o, conv_temp_o, conv_bias_hi_o;
  logic        conv_int_ref_o, conv_sclk_timed_o, sample_ext_timed_o, pin7_is_input_o;
  logic        ref2_is_input_o, dac_ref_ext_o, ref_on_o, diff_config_wr_o;
  logic        res_valid_o, res_is_temp_o, temp_pending_o, scan_busy_o;
  logic [1:0]  repeat_count_sel_i, adc_ref_o, diff_config_sel_o;
  logic [2:0]  conv_chan_o, res_chan_o;
  logic [3:0]  diff_pair_i;
  logic [7:0]  c;
  logic [11:0] conv_data_i, res_data_o, temp_result_o, th, tl, d;
  logic [4:0]  rq[$];
  logic [2:0]  eq[$], sq[$];
  int          n_mismatch, checked, dly, scans, nwr, i, k;

  adcsd_top dut (.*);
  adcsd_host_model host (.link_sclk_o(link_sclk_i), .link_cs_n_o(link_cs_n_i),
    .link_mosi_o(link_mosi_i));

  // System clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------
  function automatic logic [3:0] rt(input int r);
    return (r == 0) ? 4'h1 : (r == 1) ? 4'h6 : (r == 2) ? 4'h3 : 4'hA;
  endfunction

  // Channels a command should convert, in order
  function automatic void exp_list(input logic [7:0] b, input logic s7, input logic s6);
    int lo, hi, n, ch;
    n = b[5:3];
    lo = (b[2:1] == 2'h0) ? 0 : n;
    hi = (b[2:1] == 2'h1) ? 7 : n;
    eq.delete();
    for (ch = lo; ch <= hi; ch++)
      if (!(s7 && ch == 7) && !(s6 && ch == 6))
        if (!(diff_pair_i[ch/2] && eq.size() > 0 && eq[$] == 3'(ch & 6)))
          eq.push_back(3'(diff_pair_i[ch/2] ? ch & 6 : ch));
    if (b[2:1] == 2'h2)
      repeat (4 * repeat_count_sel_i + 3) eq.push_back(3'(n));
  endfunction

  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cfg(input logic [7:0] b);
    host.send(b);
    repeat (8) @(negedge clk_sys_i);
  endtask

  // Command a scan, pulse the start pin if asked, wait and compare channels
  task automatic scan(input logic [7:0] b, input logic pin);
    int s, w;
    s = scans;
    rq.delete();
    sq.delete();
    host.send(b);
    if (pin)
    begin
      repeat (8) @(negedge clk_sys_i);
      `CHK(scan_busy_o, 1'b0)
      convert_start_pin_n_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      convert_start_pin_n_i = 1'b1;
    end
    for (w = 0; w < 4000 && scans == s; w++)
      @(negedge clk_sys_i);
    if (scans == s)
    begin
      n_mismatch++;
      summarize();
    end
    k = 0;
    for (w = 0; w < rq.size(); w++)
      if (!rq[w][4])
      begin
        `CHK(rq[w][2:0], eq[k])
        `CHK(sq[k], eq[k])
        k++;
      end
    `CHK(k, eq.size())
  endtask

  // Converter stand-in and result monitor
  always @(negedge clk_sys_i)
  begin
    conv_done_i <= 1'b0;
    if (conv_req_o === 1'b1)
    begin
      rq.push_back({conv_temp_o, conv_bias_hi_o, conv_chan_o});
      dly = 1 + $urandom % 3;
    end
    else if (dly > 0)
    begin
      dly--;
      if (dly == 0)
      begin
        d = 12'($urandom);
        if (rq[$][4] && rq[$][3])
          th = d;
        else if (rq[$][4])
          tl = d;
        conv_done_i <= 1'b1;
        conv_data_i <= d;
      end
    end
    if (res_valid_o === 1'b1)
      `CHK(res_data_o, res_is_temp_o ? th - tl - 12'h889 : d)
    if (res_valid_o === 1'b1 && res_is_temp_o === 1'b0)
      sq.push_back(res_chan_o);
    if (diff_config_wr_o === 1'b1)
      nwr++;
    if (busy_d === 1'b1 && scan_busy_o === 1'b0)
      scans++;
    busy_d = scan_busy_o;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_i, convert_start_pin_n_i, force_ref_on_i, dac_ref_load_i} = 4'hC;
    {conv_done_i, temp_read_i, diff_pair_i, repeat_count_sel_i} = 8'h00;
    conv_data_i = 12'h000;
    {n_mismatch, checked, dly, scans, nwr, busy_d} = '0;
    void'($urandom(32'h4C50));
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    `CHK({adc_ref_o, dac_ref_ext_o, ref2_is_input_o, pin7_is_input_o}, 5'h07)
    for (i = 0; i < 4; i++)
    begin
      cfg(8'h60 | 8'(i << 2));
      `CHK({adc_ref_o, dac_ref_ext_o, ref2_is_input_o}, rt(i))
    end
    cfg(8'h1F);
    `CHK(adc_ref_o, adcsd_pkg::ADC_REF_DIFF)
    cfg(8'h74);
    `CHK({conv_sclk_timed_o, sample_ext_timed_o, pin7_is_input_o}, 3'h5)
    cfg(8'h54);
    `CHK({conv_sclk_timed_o, sample_ext_timed_o, pin7_is_input_o}, 3'h2)
    cfg(8'h44);
    `CHK(pin7_is_input_o, 1'b0)
    exp_list(8'hAA, 1'b1, 1'b1);
    scan(8'hAA, 1'b1);
    cfg(8'h61);
    `CHK(diff_config_sel_o, 2'h1)
    `CHK(nwr, 1)
    diff_pair_i = 4'h2;
    exp_list(8'h9E, 1'b0, 1'b0);
    scan(8'h9E, 1'b0);
    diff_pair_i = 4'h0;
    for (i = 0; i < 12; i++)
    begin
      repeat_count_sel_i = 2'($urandom);
      c = 8'h80 | (8'($urandom) & 8'h7E);
      exp_list(c, 1'b0, 1'b0);
      scan(c, 1'b0);
    end
    force_ref_on_i = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      exp_list(8'h8F, 1'b0, 1'b0);
      scan(8'h8F, 1'b0);
      `CHK({rq[0][4:3], rq[1][4:3]}, 4'hE)
      `CHK(temp_pending_o, 1'b1)
    end
    `CHK(temp_result_o, th - tl - 12'h889)
    temp_read_i = 1'b1;
    @(negedge clk_sys_i);
    temp_read_i = 1'b0;
    @(negedge clk_sys_i);
    `CHK(temp_pending_o, 1'b0)
    summarize();
  end
endmodule // adc_scan_setup_decode_tb
